// file: verilog/rsc_top.sv
// Reset source controller: threshold select, reset cause flags, reset scopes
// Notes on behaviour
// [R1] Four valid threshold codes 55/33/99/AA; power-on value 55.
// [R2] Any other code triggers a full reset after the software-reset delay.
// [R3] That reset restores the threshold register to 55.
// [R4] Low-voltage reset after the filter time; threshold register kept.
// [R5] Low-voltage flag, bit 2, set by hardware, cleared only by writing zero.
// [R6] Bad-code flag, bit 1, set by hardware, cleared only by writing zero.
// [R7] Flag bits 7 to 4 read zero.
// [R8] Running watchdog timeout: low-voltage-style reset plus timeout flag.
// [R9] Sleeping watchdog timeout: clear only PC and SP, set timeout flag.
// [R10] Power-on clears TO/POWERDOWN_STATUS_FLAG; LVR keeps; run WDT sets TO; sleep WDT sets both.
// [R11] Power-on resets PC, interrupts, watchdog, timer, ports, stack pointer.
// [R12] Low-voltage detection disabled in idle or sleep; the code gates it on core_sleeping only and has no idle input.
// [R13] Reset requests synchronised; internal reset held at least one cycle.
//
// Our own choices: the Avalon-MM interface to the registers and the address map.
`timescale 1ns/1ps
module rsc_top (
   input wire logic clk_sys,
   input wire logic reset_n,
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic low_supply,
   input wire logic wdt_timeout,
   input wire logic core_sleeping,
   input wire logic guard_reset_event,
   input wire logic wdt_ctrl_reset_event,
   output logic full_reset,
   output logic pc_sp_reset,
   output logic irq
);
   ////////////////////////////////////////////////////////////////////////////
   logic low_supply_s;
   logic wdt_timeout_s;
   logic sleeping_s;
   logic lowvolt_done;
   logic badcode_done;
   logic code_valid;

   // Asynchronous inputs each pass two flops
   rsc_sync u_sync_lv (.clk_sys(clk_sys), .reset_n(reset_n), .async_in(low_supply), .sync_out(low_supply_s)); // R13
   rsc_sync u_sync_wdt (.clk_sys(clk_sys), .reset_n(reset_n), .async_in(wdt_timeout), .sync_out(wdt_timeout_s));
   rsc_sync u_sync_slp (.clk_sys(clk_sys), .reset_n(reset_n), .async_in(core_sleeping), .sync_out(sleeping_s));

   logic [7:0] threshold_code;

   always_comb begin
      case (threshold_code)
         rsc_pkg::CODE_2V10, rsc_pkg::CODE_2V55, rsc_pkg::CODE_3V15, rsc_pkg::CODE_3V80: code_valid = 1'b1; // R1
         default: code_valid = 1'b0;
      endcase
   end

   logic busy;
   // Low-voltage detection gated off while sleeping and while a reset is in flight; bad-code detection only while a reset is in flight
   rsc_delay #(.LIMIT(rsc_pkg::LOWVOLT_FILTER_CYCLES)) u_lv_filter (
      .clk_sys(clk_sys),
      .reset_n(reset_n),
      .request(low_supply_s && !sleeping_s && !busy), // R4 R12
      .done(lowvolt_done)
   );
   rsc_delay #(.LIMIT(rsc_pkg::SRESET_DELAY_CYCLES)) u_code_delay (
      .clk_sys(clk_sys),
      .reset_n(reset_n),
      .request(!code_valid && !busy), // R2
      .done(badcode_done)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Reset sequencer
   typedef enum {RSC_IDLE, RSC_HOLD} rsc_state_t;
   rsc_state_t state;
   rsc_state_t next_state;
   logic [1:0] hold_count;
   logic [1:0] next_hold_count;
   logic hold_full;
   logic next_hold_full;
   logic next_full_reset;
   logic next_pc_sp_reset;
   logic wdt_seen;
   logic next_wdt_seen;
   logic wdt_rise;
   logic ev_lowvolt;
   logic ev_badcode;
   logic ev_wdt_run;
   logic ev_wdt_sleep;

   assign busy = (state != RSC_IDLE);
   assign wdt_rise = wdt_timeout_s && !wdt_seen;
   assign ev_badcode = badcode_done && !busy;
   assign ev_lowvolt = lowvolt_done && !busy && !ev_badcode;
   assign ev_wdt_run = wdt_rise && !sleeping_s && !busy && !ev_badcode && !ev_lowvolt;
   assign ev_wdt_sleep = wdt_rise && sleeping_s && !busy && !ev_badcode && !ev_lowvolt;

   always_comb begin
      next_state = state;
      next_hold_count = hold_count;
      next_hold_full = hold_full;
      next_wdt_seen = wdt_timeout_s;
      next_full_reset = 1'b0;
      next_pc_sp_reset = 1'b0;
      case (state)
         RSC_IDLE: begin
            if (ev_badcode || ev_lowvolt || ev_wdt_run || ev_wdt_sleep) begin
               next_state = RSC_HOLD;
               next_hold_count = 2'(rsc_pkg::RESET_HOLD_CYCLES - 1);
               next_hold_full = !ev_wdt_sleep; // R8 R9
               next_full_reset = !ev_wdt_sleep;
               next_pc_sp_reset = 1'b1;
            end
         end
         RSC_HOLD: begin
            next_full_reset = hold_full; // R13
            next_pc_sp_reset = 1'b1;
            if (hold_count == 2'h0) begin
               next_state = RSC_IDLE;
               next_full_reset = 1'b0;
               next_pc_sp_reset = 1'b0;
            end else begin
               next_hold_count = hold_count - 2'h1;
            end
         end
         default: next_state = RSC_IDLE;
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         state <= RSC_IDLE;
         hold_count <= 2'h0;
         hold_full <= 1'b0;
         wdt_seen <= 1'b0;
         full_reset <= 1'b1; // R11
         pc_sp_reset <= 1'b1;
      end else begin
         state <= next_state;
         hold_count <= next_hold_count;
         hold_full <= next_hold_full;
         wdt_seen <= next_wdt_seen;
         full_reset <= next_full_reset;
         pc_sp_reset <= next_pc_sp_reset;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Registers
   logic [3:0] flags;
   logic timeout_status_flag;
   logic powerdown_status_flag;
   logic [3:0] irq_status;
   logic [3:0] irq_mask;
   logic [7:0] next_threshold_code;
   logic [3:0] next_flags;
   logic next_timeout;
   logic next_powerdown;
   logic [3:0] next_irq_status;
   logic [3:0] next_irq_mask;
   logic [31:0] next_readdata;
   logic next_waitrequest;
   logic next_irq;
   logic wr_go;
   logic rd_load;

   // One wait cycle per access: waitrequest drops the cycle after a request
   assign wr_go = avs_write && !avs_waitrequest;
   // Read data loaded early so it stands while waitrequest is low
   assign rd_load = avs_read && avs_waitrequest;

   always_comb begin
      next_threshold_code = threshold_code;
      next_flags = flags;
      next_timeout = timeout_status_flag;
      next_powerdown = powerdown_status_flag;
      next_irq_status = irq_status;
      next_irq_mask = irq_mask;
      next_readdata = avs_readdata;
      next_waitrequest = !((avs_read || avs_write) && avs_waitrequest);
      if (wr_go) begin
         case (avs_address)
            rsc_pkg::ADDR_THRESHOLD: next_threshold_code = avs_writedata[7:0];
            rsc_pkg::ADDR_FLAGS: next_flags = flags & avs_writedata[3:0]; // R5 R6
            rsc_pkg::ADDR_STATUS: begin
               next_timeout = avs_writedata[rsc_pkg::STAT_TIMEOUT];
               next_powerdown = avs_writedata[rsc_pkg::STAT_POWERDOWN];
            end
            rsc_pkg::ADDR_IRQ_STATUS: begin
               // Bit 8 selects a mask load instead of a status clear
               if (avs_writedata[8]) begin
                  next_irq_mask = avs_writedata[3:0];
               end else begin
                  next_irq_status = irq_status & ~avs_writedata[3:0];
               end
            end
            default: next_irq_mask = irq_mask;
         endcase
      end
      if (rd_load) begin
         case (avs_address)
            rsc_pkg::ADDR_THRESHOLD: next_readdata = {24'h000000, threshold_code};
            rsc_pkg::ADDR_FLAGS: next_readdata = {28'h0000000, flags}; // R7
            rsc_pkg::ADDR_STATUS: next_readdata = {30'h00000000, powerdown_status_flag, timeout_status_flag};
            rsc_pkg::ADDR_IRQ_STATUS: next_readdata = {28'h0000000, irq_status};
            default: next_readdata = 32'h00000000;
         endcase
      end
      // Events win over a same-cycle software clear
      if (ev_lowvolt) begin
         next_flags[rsc_pkg::FLAG_LOWVOLT] = 1'b1; // R5
         next_irq_status[rsc_pkg::IRQ_LOWVOLT] = 1'b1;
      end
      if (ev_badcode) begin
         next_flags[rsc_pkg::FLAG_BADCODE] = 1'b1; // R6
         next_irq_status[rsc_pkg::IRQ_BADCODE] = 1'b1;
         next_threshold_code = rsc_pkg::THRESHOLD_POR; // R3
      end
      if (guard_reset_event) begin
         next_flags[rsc_pkg::FLAG_GUARD] = 1'b1;
      end
      if (wdt_ctrl_reset_event) begin
         next_flags[rsc_pkg::FLAG_WATCHDOG] = 1'b1;
      end
      if (ev_wdt_run) begin
         next_timeout = 1'b1; // R8 R10
         next_irq_status[rsc_pkg::IRQ_WDT_RUN] = 1'b1;
      end
      if (ev_wdt_sleep) begin
         next_timeout = 1'b1; // R9 R10
         next_powerdown = 1'b1;
         next_irq_status[rsc_pkg::IRQ_WDT_SLEEP] = 1'b1;
      end
      next_irq = |(next_irq_status & next_irq_mask);
   end

   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         threshold_code <= rsc_pkg::THRESHOLD_POR; // R1 R11
         flags <= 4'h0;
         timeout_status_flag <= 1'b0; // R10
         powerdown_status_flag <= 1'b0;
         irq_status <= 4'h0;
         irq_mask <= 4'h0;
         avs_readdata <= 32'h00000000;
         avs_waitrequest <= 1'b1;
         irq <= 1'b0;
      end else begin
         threshold_code <= next_threshold_code;
         flags <= next_flags;
         timeout_status_flag <= next_timeout;
         powerdown_status_flag <= next_powerdown;
         irq_status <= next_irq_status;
         irq_mask <= next_irq_mask;
         avs_readdata <= next_readdata;
         avs_waitrequest <= next_waitrequest;
         irq <= next_irq;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   a_badcode_restore: assert property (@(posedge clk_sys) disable iff (!reset_n)
      ev_badcode |=> threshold_code == rsc_pkg::THRESHOLD_POR) else $error("code not restored"); // R3
   a_badcode_flag: assert property (@(posedge clk_sys) disable iff (!reset_n)
      ev_badcode |=> flags[rsc_pkg::FLAG_BADCODE] && full_reset) else $error("bad code flag missing"); // R6
   a_lowvolt_keep: assert property (@(posedge clk_sys) disable iff (!reset_n)
      ev_lowvolt && !wr_go |=> $stable(threshold_code) && flags[rsc_pkg::FLAG_LOWVOLT]) else $error("lvr wrong"); // R4
   a_flag_sticky: assert property (@(posedge clk_sys) disable iff (!reset_n)
      flags[rsc_pkg::FLAG_LOWVOLT] && !(wr_go && avs_address == rsc_pkg::ADDR_FLAGS)
      |=> flags[rsc_pkg::FLAG_LOWVOLT]) else $error("lvr flag dropped"); // R5
   a_upper_zero: assert property (@(posedge clk_sys) disable iff (!reset_n)
      rd_load && avs_address == rsc_pkg::ADDR_FLAGS |=> avs_readdata[7:4] == 4'h0) else $error("upper bits"); // R7
   a_wdt_run: assert property (@(posedge clk_sys) disable iff (!reset_n)
      ev_wdt_run |=> full_reset && timeout_status_flag ##1 full_reset) else $error("run wdt scope"); // R8
   a_wdt_sleep: assert property (@(posedge clk_sys) disable iff (!reset_n)
      ev_wdt_sleep |=> pc_sp_reset && !full_reset && timeout_status_flag && powerdown_status_flag)
      else $error("sleep wdt scope"); // R9
   a_lvr_status: assert property (@(posedge clk_sys) disable iff (!reset_n)
      ev_lowvolt && !wr_go |=> $stable(timeout_status_flag) && $stable(powerdown_status_flag))
      else $error("lvr changed status"); // R10
   a_sleep_no_lvr: assert property (@(posedge clk_sys) disable iff (!reset_n)
      sleeping_s |-> !lowvolt_done || busy || $past(!sleeping_s)) else $error("lvr while asleep"); // R12
   a_hold_min: assert property (@(posedge clk_sys) disable iff (!reset_n)
      $rose(pc_sp_reset) |=> pc_sp_reset) else $error("reset too short"); // R13
   c_badcode: cover property (@(posedge clk_sys) disable iff (!reset_n) ev_badcode);
   c_lowvolt: cover property (@(posedge clk_sys) disable iff (!reset_n) ev_lowvolt);
   c_wdt_sleep: cover property (@(posedge clk_sys) disable iff (!reset_n) ev_wdt_sleep);
endmodule : rsc_top

// file: verilog/rsc_pkg.sv
// Package: register map, codes and timing constants of the reset source controller
package rsc_pkg;
   // Register byte addresses (word aligned)
   localparam logic [3:0] ADDR_THRESHOLD = 4'h0;
   localparam logic [3:0] ADDR_FLAGS = 4'h4;
   localparam logic [3:0] ADDR_STATUS = 4'h8;
   localparam logic [3:0] ADDR_IRQ_STATUS = 4'hC;
   localparam logic [3:0] ADDR_IRQ_MASK = 4'h0;
   localparam logic [1:0] ADDR_HI_MASK_PAGE = 2'h1;
   // Threshold codes
   localparam logic [7:0] CODE_2V10 = 8'h55;
   localparam logic [7:0] CODE_2V55 = 8'h33;
   localparam logic [7:0] CODE_3V15 = 8'h99;
   localparam logic [7:0] CODE_3V80 = 8'hAA;
   localparam logic [7:0] THRESHOLD_POR = 8'h55;
   // Flag register bit positions
   localparam int FLAG_GUARD = 3;
   localparam int FLAG_LOWVOLT = 2;
   localparam int FLAG_BADCODE = 1;
   localparam int FLAG_WATCHDOG = 0;
   // Status register bit positions
   localparam int STAT_TIMEOUT = 0;
   localparam int STAT_POWERDOWN = 1;
   // Interrupt bit positions
   localparam int IRQ_LOWVOLT = 0;
   localparam int IRQ_BADCODE = 1;
   localparam int IRQ_WDT_RUN = 2;
   localparam int IRQ_WDT_SLEEP = 3;
   // Timing
   localparam int CLK_HZ = 10_000_000;
   localparam int LOWVOLT_FILTER_TIME_US = 120;
   localparam int SRESET_DELAY_US = 45;
   localparam int LOWVOLT_FILTER_CYCLES = (LOWVOLT_FILTER_TIME_US * (CLK_HZ / 1_000_000));
   localparam int SRESET_DELAY_CYCLES = (SRESET_DELAY_US * (CLK_HZ / 1_000_000));
   localparam int RESET_HOLD_CYCLES = 2;
endpackage : rsc_pkg

// file: verilog/rsc_sync.sv
// Two-flop synchroniser for one asynchronous level
`timescale 1ns/1ps
module rsc_sync (
   input wire logic clk_sys,
   input wire logic reset_n,
   input wire logic async_in,
   output logic sync_out
);
   logic stage1;
   logic next_stage1;
   logic next_sync_out;

   always_comb begin
      next_stage1 = async_in;
      next_sync_out = stage1;
   end

   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         stage1 <= 1'b0;
         sync_out <= 1'b0;
      end else begin
         stage1 <= next_stage1;
         sync_out <= next_sync_out;
      end
   end
endmodule : rsc_sync

// file: verilog/rsc_delay.sv
// Persistence counter: done once the request has held for LIMIT+1 cycles
`timescale 1ns/1ps
module rsc_delay #(
   parameter int LIMIT = 4
) (
   input wire logic clk_sys,
   input wire logic reset_n,
   input wire logic request,
   output logic done
);
   logic [15:0] count;
   logic [15:0] next_count;
   logic next_done;

   always_comb begin
      next_count = 16'h0000;
      next_done = 1'b0;
      if (request) begin
         if (count >= 16'(LIMIT)) begin
            next_count = count;
            next_done = 1'b1;
         end else begin
            next_count = count + 16'h0001;
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         count <= 16'h0000;
         done <= 1'b0;
      end else begin
         count <= next_count;
         done <= next_done;
      end
   end
endmodule : rsc_delay

// file: tb/reset_source_control_test.sv
// Self-checking bench for the reset source controller
`timescale 1ns/1ps
`define CHK(g, e, s) begin num_checks++; if ((g) !== (e)) begin bad_count++; $display("CHECK FAILED t=%0t %s", $time, s); end end
module reset_source_control_test;
   logic clk_sys = 1'b0;
   logic reset_n = 1'b0;
   logic [3:0] avs_address = 4'h0;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic low_supply = 1'b0;
   logic wdt_timeout = 1'b0;
   logic core_sleeping = 1'b0;
   logic guard_reset_event = 1'b0;
   logic wdt_ctrl_reset_event = 1'b0;
   logic full_reset;
   logic pc_sp_reset;
   logic irq;
   int bad_count = 0;
   int num_checks = 0;
   logic [31:0] m_thr, m_flg, m_sta, m_irq;
   logic [7:0] codes [4];
   logic [7:0] c;
   int n;
   always #50 clk_sys = ~clk_sys;
   rsc_top u_rsc_top (
      .clk_sys(clk_sys),
      .reset_n(reset_n),
      .avs_address(avs_address),
      .avs_read(avs_read),
      .avs_write(avs_write),
      .avs_writedata(avs_writedata),
      .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest),
      .low_supply(low_supply),
      .wdt_timeout(wdt_timeout),
      .core_sleeping(core_sleeping),
      .guard_reset_event(guard_reset_event),
      .wdt_ctrl_reset_event(wdt_ctrl_reset_event),
      .full_reset(full_reset),
      .pc_sp_reset(pc_sp_reset),
      .irq(irq)
   );
   ////////////////////////////////////////////////////////////////////////////
   task automatic end_sim();
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : end_sim
   // Request held until the rising edge that samples waitrequest low
   task automatic bus(input logic we, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
      int k;
      k = 0;
      @(posedge clk_sys);
      avs_address <= a;
      avs_writedata <= d;
      avs_read <= ~we;
      avs_write <= we;
      do begin
         @(posedge clk_sys);
         k++;
      end while (avs_waitrequest !== 1'b0 && k < 50);
      `CHK(k < 50, 1'b1, "bus access hung")
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask : bus
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
      case (a)
         rsc_pkg::ADDR_THRESHOLD: m_thr = d & 32'hFF;
         rsc_pkg::ADDR_FLAGS: m_flg = m_flg & d & 32'hF;
         rsc_pkg::ADDR_STATUS: m_sta = d & 32'h3;
         rsc_pkg::ADDR_IRQ_STATUS: if (!d[8]) m_irq = m_irq & ~d & 32'hF;
         default: ;
      endcase
   endtask : wr
   task automatic rd(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
      logic [31:0] q;
      bus(1'b0, a, 32'h0, q);
      `CHK(q & m, e & m, "register read")
   endtask : rd
   // Counts cycles until a reset pulse shows, gives up at the limit
   task automatic wait_pulse(input int lim, output int k);
      k = 0;
      while (full_reset !== 1'b1 && pc_sp_reset !== 1'b1 && k < lim) begin
         @(negedge clk_sys);
         k++;
      end
   endtask : wait_pulse
   task automatic pulse_end();
      @(negedge clk_sys);
      `CHK(pc_sp_reset, 1'b1, "reset pulse too short")
      repeat (6) @(negedge clk_sys);
   endtask : pulse_end
   task automatic do_reset();
      @(posedge clk_sys);
      reset_n <= 1'b0;
      repeat (2) @(posedge clk_sys);
      `CHK({full_reset, pc_sp_reset}, 2'b11, "reset outputs during reset")
      reset_n <= 1'b1;
      m_thr = 32'h55;
      m_flg = 32'h0;
      m_sta = 32'h0;
      m_irq = 32'h0;
   endtask : do_reset
   task automatic irq_chk(input logic [3:0] a, input logic [31:0] d, input logic e);
      wr(a, d);
      repeat (2) @(negedge clk_sys);
      `CHK(irq, e, "interrupt level")
   endtask : irq_chk
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      #3_000_000;
      bad_count++;
      $display("CHECK FAILED t=%0t watchdog expired", $time);
      end_sim();
   end
   initial begin
      void'($urandom(32'h70e1));
      codes = '{rsc_pkg::CODE_2V55, rsc_pkg::CODE_3V15, rsc_pkg::CODE_3V80, rsc_pkg::CODE_2V10};
      do_reset();
      rd(rsc_pkg::ADDR_THRESHOLD, 32'hFF, rsc_pkg::THRESHOLD_POR);
      rd(rsc_pkg::ADDR_FLAGS, 32'hFFFF_FFFB, 32'h0);
      rd(rsc_pkg::ADDR_STATUS, 32'h3, m_sta);
      wr(rsc_pkg::ADDR_IRQ_STATUS, 32'h100);
      wr(rsc_pkg::ADDR_IRQ_STATUS, 32'hF);
      wr(rsc_pkg::ADDR_FLAGS, 32'h0);
      wr(4'h2, $urandom);
      rd(4'h1, 32'hFFFF_FFFF, 32'h0);
      rd(rsc_pkg::ADDR_THRESHOLD, 32'hFF, m_thr);
      @(posedge clk_sys) guard_reset_event <= 1'b1;
      @(posedge clk_sys) guard_reset_event <= 1'b0;
      wdt_ctrl_reset_event <= 1'b1;
      @(posedge clk_sys) wdt_ctrl_reset_event <= 1'b0;
      m_flg = 32'h9;
      rd(rsc_pkg::ADDR_FLAGS, 32'hFFFF_FFFF, m_flg);
      wr(rsc_pkg::ADDR_FLAGS, 32'hF6);
      rd(rsc_pkg::ADDR_FLAGS, 32'hFFFF_FFFF, m_flg);
      foreach (codes[i]) begin
         wr(rsc_pkg::ADDR_THRESHOLD, {24'h0, codes[i]});
         rd(rsc_pkg::ADDR_THRESHOLD, 32'hFF, m_thr);
         wait_pulse(600, n);
         `CHK(n, 600, "reset on valid code")
      end
      do c = 8'($urandom);
      while (c inside {8'h55, 8'h33, 8'h99, 8'hAA});
      wr(rsc_pkg::ADDR_THRESHOLD, {24'h0, c});
      wait_pulse(700, n);
      `CHK(n >= rsc_pkg::SRESET_DELAY_CYCLES && n <= rsc_pkg::SRESET_DELAY_CYCLES + 10, 1'b1, "bad code delay")
      `CHK(full_reset, 1'b1, "bad code reset kind")
      pulse_end();
      m_thr = 32'h55;
      m_flg = m_flg | 32'h2;
      m_irq = m_irq | 32'h2;
      rd(rsc_pkg::ADDR_THRESHOLD, 32'hFF, m_thr);
      rd(rsc_pkg::ADDR_FLAGS, 32'hFF, m_flg);
      wr(rsc_pkg::ADDR_FLAGS, 32'hFF);
      rd(rsc_pkg::ADDR_FLAGS, 32'hFF, m_flg);
      wr(rsc_pkg::ADDR_FLAGS, 32'hFD);
      rd(rsc_pkg::ADDR_FLAGS, 32'hFF, m_flg);
      wr(rsc_pkg::ADDR_THRESHOLD, 32'h99);
      wr(rsc_pkg::ADDR_STATUS, 32'h3);
      // Short dip must be filtered out
      low_supply <= 1'b1;
      wait_pulse(600, n);
      `CHK(n, 600, "short low supply reset")
      low_supply <= 1'b0;
      repeat (10) @(posedge clk_sys);
      low_supply <= 1'b1;
      wait_pulse(1400, n);
      `CHK(n >= rsc_pkg::LOWVOLT_FILTER_CYCLES && n <= rsc_pkg::LOWVOLT_FILTER_CYCLES + 10, 1'b1, "filter time")
      `CHK(full_reset, 1'b1, "low voltage reset kind")
      low_supply <= 1'b0;
      pulse_end();
      m_flg = m_flg | 32'h4;
      m_irq = m_irq | 32'h1;
      rd(rsc_pkg::ADDR_THRESHOLD, 32'hFF, m_thr);
      rd(rsc_pkg::ADDR_FLAGS, 32'hFF, m_flg);
      rd(rsc_pkg::ADDR_STATUS, 32'h3, m_sta);
      wr(rsc_pkg::ADDR_FLAGS, 32'hFB);
      rd(rsc_pkg::ADDR_FLAGS, 32'hFF, m_flg);
      core_sleeping <= 1'b1;
      low_supply <= 1'b1;
      wait_pulse(1400, n);
      `CHK(n, 1400, "low voltage reset while asleep")
      low_supply <= 1'b0;
      wr(rsc_pkg::ADDR_THRESHOLD, 32'h33);
      wr(rsc_pkg::ADDR_STATUS, 32'h0);
      @(posedge clk_sys) wdt_timeout <= 1'b1;
      wait_pulse(20, n);
      `CHK({full_reset, pc_sp_reset}, 2'b01, "sleep timeout reset scope")
      wdt_timeout <= 1'b0;
      pulse_end();
      m_sta = 32'h3;
      m_irq = m_irq | 32'h8;
      rd(rsc_pkg::ADDR_STATUS, 32'h3, m_sta);
      rd(rsc_pkg::ADDR_THRESHOLD, 32'hFF, m_thr);
      core_sleeping <= 1'b0;
      wr(rsc_pkg::ADDR_STATUS, 32'h0);
      @(posedge clk_sys) wdt_timeout <= 1'b1;
      wait_pulse(20, n);
      `CHK({full_reset, pc_sp_reset}, 2'b11, "run timeout reset scope")
      wdt_timeout <= 1'b0;
      pulse_end();
      m_sta = 32'h1;
      m_irq = m_irq | 32'h4;
      rd(rsc_pkg::ADDR_STATUS, 32'h3, m_sta);
      rd(rsc_pkg::ADDR_IRQ_STATUS, 32'hF, m_irq);
      `CHK(irq, 1'b0, "masked interrupt")
      irq_chk(rsc_pkg::ADDR_IRQ_STATUS, 32'h104, 1'b1);
      irq_chk(rsc_pkg::ADDR_IRQ_STATUS, 32'h4, 1'b0);
      irq_chk(rsc_pkg::ADDR_IRQ_STATUS, 32'h10F, 1'b1);
      irq_chk(rsc_pkg::ADDR_IRQ_STATUS, 32'hB, 1'b0);
      rd(rsc_pkg::ADDR_IRQ_STATUS, 32'hF, m_irq);
      // Second power-on in mid-run
      wr(rsc_pkg::ADDR_STATUS, 32'h3);
      do_reset();
      rd(rsc_pkg::ADDR_STATUS, 32'h3, m_sta);
      rd(rsc_pkg::ADDR_THRESHOLD, 32'hFF, m_thr);
      rd(rsc_pkg::ADDR_FLAGS, 32'hFFFF_FFFB, m_flg);
      end_sim();
   end
endmodule : reset_source_control_test
